// ---- hw/adcgmd_gain_decode.sv ----
`timescale 1ns/10ps
module adcgmd_gain_decode (
    // Clock and synchronised reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Gain code in, decoded level out.
    adcgmd_gain_if.dec       gain
);

    logic signed [10:0] level_wide;
    logic signed [9:0]  level_next;
    logic               silent_next;
    logic signed [9:0]  level_reg;
    logic               silent_reg;

    // Each code step lowers the gain by three eighths of a dB from +60 dB.
    assign level_wide  = adcgmd_pkg::GAIN_TOP_EIGHTHS
                       - adcgmd_pkg::GAIN_STEP_EIGHTHS * $signed({3'b000, gain.code});
    assign level_next  = level_wide[9:0];
    assign silent_next = (gain.code == adcgmd_pkg::GAIN_MUTE_CODE) || gain.mute_all;

    // Registered so the top outputs come straight from flip-flops.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            level_reg  <= adcgmd_pkg::GAIN_RST_LEVEL;
            silent_reg <= 1'b0;
        end else begin
            level_reg  <= level_next;
            silent_reg <= silent_next;
        end
    end

    assign gain.level  = level_reg;
    assign gain.silent = silent_reg;

endmodule

// ---- hw/adcgmd_regs.sv ----
//
// Function
// - Channel 2 gain is an 8-bit read-write field resetting to 0xA0, 0 dB.
// - Gain code 0 is +60 dB, each step -0.375 dB; code 0xFF mutes.
// - Channels 2, 3, 4 have identical gain registers at 0x0B, 0x0C, 0x0D.
// - Bits 7:6 select normal, two-channel or one-channel summing; 11 reserved.
// - Control register resets 0x02; bit 4 mutes all, bit 0 starts calibration.
// - Bits 3:0 enable fault checking per channel, all enabled after reset.
// - Channel 1 report bits 4, 3, 2: positive input to supply, ground, bias.
// - Channel 1 report bits 1, 0: negative input to supply, ground.
// - Report resets 0x00; bit 6 terminals bridged, bit 5 input open.
//
`timescale 1ns/10ps
module adcgmd_regs (
    // Clock and reset.
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    // Register access from the control port decoder.
    input  wire logic [7:0]                    i_reg_addr,
    input  wire logic [7:0]                    i_reg_wdata,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    output logic      [7:0]                    o_reg_rdata,
    output logic                               o_reg_rvalid,
    // Raw fault detector levels for channel 1, bit order as the report.
    input  wire logic [6:0]                    i_ch1_fault_raw,
    // Decoded gain for channels 2 to 4, index 0 is channel 2.
    output logic      [2:0][9:0]               o_gain_level,
    output logic      [2:0]                    o_gain_silent,
    // Control outputs.
    output logic      [1:0]                    o_channel_combine_select,
    output logic                               o_global_silence,
    output logic                               o_offset_calibration_start,
    output logic      [3:0]                    o_fault_check_on
);

    // Reset release through two flip-flops.
    logic       rst_meta_reg;
    logic       rst_sync_reg;
    logic       rst_b;

    // Register storage.
    logic [7:0] gain_reg [adcgmd_pkg::NUM_GAIN_CH];
    logic [7:0] misc_reg;
    logic [7:0] misc_next;
    logic [7:0] fault_en_reg;
    logic [7:0] fault_en_next;
    logic [7:0] faults_reg;
    logic [7:0] faults_next;

    // Fault pin synchroniser.
    logic [6:0] fault_meta_reg;
    logic [6:0] fault_sync_reg;

    // Decode and read path wires.
    logic       wr_misc;
    logic       wr_fault_en;
    logic       wr_faults;
    logic       rd_faults;
    logic [6:0] fault_seen;
    logic [6:0] fault_keep;
    logic [7:0] rdata_sel;
    logic [7:0] rdata_next;
    adcgmd_pkg::adcgmd_sum_t combine_mode;
    logic [1:0] combine_next;

    // Offset hits, one per mapped register.
    logic       hit_ch2_gain;
    logic       hit_ch3_gain;
    logic       hit_ch4_gain;
    logic       hit_misc;
    logic       hit_fault_en;
    logic       hit_ch1_faults;

    // Named fields of the stored registers.
    logic [7:0] ch2_gain_code;
    logic [7:0] ch3_gain_code;
    logic [7:0] ch4_gain_code;
    logic [1:0] channel_combine_select;
    logic       global_silence;
    logic       offset_calibration_start;
    logic       ch1_fault_check_on;
    logic       ch2_fault_check_on;
    logic       ch3_fault_check_on;
    logic       ch4_fault_check_on;

    // Named flags of the channel 1 fault report.
    logic       ch1_terminals_bridged;
    logic       ch1_input_open;
    logic       ch1_pos_to_supply;
    logic       ch1_pos_to_ground;
    logic       ch1_pos_to_bias;
    logic       ch1_neg_to_supply;
    logic       ch1_neg_to_ground;
    logic [7:0] report_word;

    // True when an access addresses the given offset.
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
        addr_hit = (addr == offset);
    endfunction

    // Reset synchroniser: assert at once, release after two edges.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_b = rst_sync_reg;

    // Fault detector levels come from the analog side, so they are synchronised first.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_meta_reg <= 7'h00;
            fault_sync_reg <= 7'h00;
        end else begin
            fault_meta_reg <= i_ch1_fault_raw;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    // Gain registers, one per channel at consecutive offsets.
    genvar gi;
    generate
        for (gi = 0; gi < adcgmd_pkg::NUM_GAIN_CH; gi++) begin : g_gain
            logic          wr_gain;
            logic [7:0]    gain_next;
            adcgmd_gain_if gain_bus ();

            assign wr_gain   = i_reg_wr && addr_hit(i_reg_addr, adcgmd_pkg::ADDR_CH2_GAIN + 8'(gi));
            assign gain_next = wr_gain ? i_reg_wdata : gain_reg[gi];

            // Whole-byte read-write gain code.
            always_ff @(posedge i_clk or negedge rst_b) begin
                if (!rst_b) begin
                    gain_reg[gi] <= adcgmd_pkg::RST_GAIN;
                end else begin
                    gain_reg[gi] <= gain_next;
                end
            end

            // The master mute also silences every decoded channel.
            assign gain_bus.code     = gain_reg[gi];
            assign gain_bus.mute_all = misc_reg[adcgmd_pkg::POS_SILENCE];

            adcgmd_gain_decode u_decode (
                .i_clk   (i_clk),
                .i_rst_b (rst_b),
                .gain    (gain_bus.dec)
            );

            assign o_gain_level[gi]  = gain_bus.level;
            assign o_gain_silent[gi] = gain_bus.silent;
        end
    endgenerate

    // Offset hits, shared by the control, enable and report write strobes and the read selection.
    assign hit_ch2_gain   = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_CH2_GAIN);
    assign hit_ch3_gain   = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_CH3_GAIN);
    assign hit_ch4_gain   = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_CH4_GAIN);
    assign hit_misc       = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_MISC_CTRL);
    assign hit_fault_en   = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_FAULT_EN);
    assign hit_ch1_faults = addr_hit(i_reg_addr, adcgmd_pkg::ADDR_CH1_FAULTS);

    // Write decode for the control, enable and report registers.
    assign wr_misc     = i_reg_wr && hit_misc;
    assign wr_fault_en = i_reg_wr && hit_fault_en;
    assign wr_faults   = i_reg_wr && hit_ch1_faults;
    assign rd_faults   = i_reg_rd && hit_ch1_faults;

    // Every bit of the control register is stored as written, reserved ones included.
    assign misc_next     = wr_misc ? i_reg_wdata : misc_reg;
    assign fault_en_next = wr_fault_en ? i_reg_wdata : fault_en_reg;

    // Named fields of the stored registers, read by the read path and the output flops.
    assign ch2_gain_code            = gain_reg[0];
    assign ch3_gain_code            = gain_reg[1];
    assign ch4_gain_code            = gain_reg[2];
    assign channel_combine_select   = misc_reg[adcgmd_pkg::POS_COMBINE_HI:adcgmd_pkg::POS_COMBINE_LO];
    assign global_silence           = misc_reg[adcgmd_pkg::POS_SILENCE];
    assign offset_calibration_start = misc_reg[adcgmd_pkg::POS_CAL_START];
    assign ch1_fault_check_on       = fault_en_reg[0];
    assign ch2_fault_check_on       = fault_en_reg[1];
    assign ch3_fault_check_on       = fault_en_reg[2];
    assign ch4_fault_check_on       = fault_en_reg[3];

    // Faults are caught only while channel 1 checking is on.
    assign fault_seen = fault_sync_reg & {adcgmd_pkg::FAULT_BITS{ch1_fault_check_on}};

    // Flags hold until read; a fault present in the reading cycle stays set.
    assign fault_keep  = rd_faults ? 7'h00 : faults_reg[6:0];
    assign faults_next = {wr_faults ? i_reg_wdata[adcgmd_pkg::POS_RESERVED_HI]
                                    : faults_reg[adcgmd_pkg::POS_RESERVED_HI],
                          fault_keep | fault_seen};

    // Report flags by name; bit 7 is a plain stored bit that reads back as written.
    assign ch1_terminals_bridged = faults_reg[6];
    assign ch1_input_open        = faults_reg[5];
    assign ch1_pos_to_supply     = faults_reg[4];
    assign ch1_pos_to_ground     = faults_reg[3];
    assign ch1_pos_to_bias       = faults_reg[2];
    assign ch1_neg_to_supply     = faults_reg[1];
    assign ch1_neg_to_ground     = faults_reg[0];
    assign report_word = {faults_reg[adcgmd_pkg::POS_RESERVED_HI], ch1_terminals_bridged, ch1_input_open,
                          ch1_pos_to_supply, ch1_pos_to_ground, ch1_pos_to_bias,
                          ch1_neg_to_supply, ch1_neg_to_ground};

    // Control register; reserved bits are kept exactly as the host wrote them.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            misc_reg <= adcgmd_pkg::RST_MISC_CTRL;
        end else begin
            misc_reg <= misc_next;
        end
    end

    // Fault check enable register.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_en_reg <= adcgmd_pkg::RST_FAULT_EN;
        end else begin
            fault_en_reg <= fault_en_next;
        end
    end

    // Channel 1 fault report; a fault in the reading cycle wins over the clear.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            faults_reg <= adcgmd_pkg::RST_CH1_FAULTS;
        end else begin
            faults_reg <= faults_next;
        end
    end

    // Read selection; unmapped offsets read as zero.
    assign rdata_sel =
        hit_ch2_gain   ? ch2_gain_code :
        hit_ch3_gain   ? ch3_gain_code :
        hit_ch4_gain   ? ch4_gain_code :
        hit_misc       ? misc_reg      :
        hit_fault_en   ? fault_en_reg  :
        hit_ch1_faults ? report_word   :
        adcgmd_pkg::RST_RDATA;
    assign rdata_next = i_reg_rd ? rdata_sel : o_reg_rdata;

    // Read data, one cycle after the strobe; it holds until the next read.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_reg_rdata <= adcgmd_pkg::RST_RDATA;
        end else begin
            o_reg_rdata <= rdata_next;
        end
    end

    // Read valid, a one-cycle pulse in the answer cycle.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // Combining mode; the reserved code falls back to normal operation.
    assign combine_mode = adcgmd_pkg::adcgmd_sum_t'(channel_combine_select);
    assign combine_next = (combine_mode == adcgmd_pkg::ADCGMD_SUM_TWO) ? 2'h1 :
                          (combine_mode == adcgmd_pkg::ADCGMD_SUM_ONE) ? 2'h2 :
                          2'h0;

    // Combining select output flop.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_channel_combine_select <= 2'h0;
        end else begin
            o_channel_combine_select <= combine_next;
        end
    end

    // Master mute output flop.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_global_silence <= 1'b0;
        end else begin
            o_global_silence <= global_silence;
        end
    end

    // Calibration start mirrors its bit as a level; it does not clear itself.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_offset_calibration_start <= 1'b0;
        end else begin
            o_offset_calibration_start <= offset_calibration_start;
        end
    end

    // Fault check enable output flops, channel 4 in the top bit.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_fault_check_on <= adcgmd_pkg::RST_FAULT_EN[3:0];
        end else begin
            o_fault_check_on <= {ch4_fault_check_on, ch3_fault_check_on, ch2_fault_check_on, ch1_fault_check_on};
        end
    end

endmodule

// ---- pkg/adcgmd_gain_if.sv ----
`timescale 1ns/10ps
interface adcgmd_gain_if;
    logic [7:0]        code;
    logic              mute_all;
    logic signed [9:0] level;
    logic              silent;

    modport ctrl (output code, output mute_all, input level, input silent);
    modport dec  (input code, input mute_all, output level, output silent);
endinterface

// ---- pkg/adcgmd_pkg.sv ----
package adcgmd_pkg;

    // Register offsets on the control port.
    localparam logic [7:0] ADDR_CH2_GAIN   = 8'h0B;
    localparam logic [7:0] ADDR_CH3_GAIN   = 8'h0C;
    localparam logic [7:0] ADDR_CH4_GAIN   = 8'h0D;
    localparam logic [7:0] ADDR_MISC_CTRL  = 8'h0E;
    localparam logic [7:0] ADDR_FAULT_EN   = 8'h10;
    localparam logic [7:0] ADDR_CH1_FAULTS = 8'h11;

    // Values after reset.
    localparam logic [7:0] RST_GAIN        = 8'hA0;
    localparam logic [7:0] RST_MISC_CTRL   = 8'h02;
    localparam logic [7:0] RST_FAULT_EN    = 8'h0F;
    localparam logic [7:0] RST_CH1_FAULTS  = 8'h00;
    localparam logic [7:0] RST_RDATA       = 8'h00;

    // Field positions of the miscellaneous control register.
    localparam int         POS_COMBINE_HI  = 7;
    localparam int         POS_COMBINE_LO  = 6;
    localparam int         POS_SILENCE     = 4;
    localparam int         POS_CAL_START   = 0;

    // Field positions of the channel 1 fault report.
    localparam int         POS_RESERVED_HI = 7;
    localparam int         FAULT_BITS      = 7;
    localparam int         NUM_FAULT_EN    = 4;

    // Gain decoding: level in steps of 0.125 dB.
    localparam int         NUM_GAIN_CH     = 3;
    localparam logic [7:0] GAIN_MUTE_CODE  = 8'hFF;
    localparam logic signed [10:0] GAIN_TOP_EIGHTHS = 11'sh1E0;
    localparam logic signed [10:0] GAIN_STEP_EIGHTHS = 11'sh003;
    localparam logic signed [9:0]  GAIN_RST_LEVEL = 10'sh000;

    // Channel combining modes.
    typedef enum logic [1:0] {
        ADCGMD_SUM_NONE,
        ADCGMD_SUM_TWO,
        ADCGMD_SUM_ONE,
        ADCGMD_SUM_RSVD
    } adcgmd_sum_t;

endpackage

// ---- tb/adcgmd_mic_model.sv ----
`timescale 1ns/10ps
module adcgmd_mic_model (
    // Clock of the detector sampling.
    input  wire logic       i_clk,
    // Fault pattern requested by the bench, report bit order.
    input  wire logic [6:0] i_fault_set,
    // Detector levels seen by the device.
    output logic      [6:0] o_fault_raw
);
    // Detector levels change a cycle after the request, as a comparator would settle.
    always_ff @(posedge i_clk) begin
        o_fault_raw <= i_fault_set;
    end
endmodule

// ---- tb/adcgmd_regs_bench.sv ----
`timescale 1ns/10ps
module adcgmd_regs_bench;
    logic            i_clk, i_rst_b, i_reg_wr, i_reg_rd, o_reg_rvalid, o_global_silence, o_offset_calibration_start;
    logic [7:0]      i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [6:0]      fault_set, fault_raw;
    logic [2:0][9:0] o_gain_level;
    logic [2:0]      o_gain_silent;
    logic [1:0]      o_channel_combine_select;
    logic [3:0]      o_fault_check_on;
    logic [7:0]      d;
    int              error_cnt = 0;
    int              cmp_count = 0;

    adcgmd_mic_model u_mic (.i_clk(i_clk), .i_fault_set(fault_set), .o_fault_raw(fault_raw));
    adcgmd_regs u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_ch1_fault_raw(fault_raw), .o_gain_level(o_gain_level), .o_gain_silent(o_gain_silent),
        .o_channel_combine_select(o_channel_combine_select), .o_global_silence(o_global_silence),
        .o_offset_calibration_start(o_offset_calibration_start), .o_fault_check_on(o_fault_check_on));

    // Compares one value and records a mismatch.
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // One write strobe, then waits until the outputs carry it.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= v;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    // One read strobe; data and valid are looked at in the answer cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk("rvalid", {9'h000, o_reg_rvalid}, 10'h001);
        chk("rdata", {2'h0, o_reg_rdata}, {2'h0, exp});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Free-running 40 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        summarize;
    end
    // Main sequence of register accesses.
    initial begin
        i_rst_b = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        fault_set = 7'h00;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk("check_on", {6'h00, o_fault_check_on}, 10'h00F);
        chk("level2", o_gain_level[0], 10'h000);
        rd(adcgmd_pkg::ADDR_CH2_GAIN, 8'hA0);
        rd(adcgmd_pkg::ADDR_CH3_GAIN, 8'hA0);
        rd(adcgmd_pkg::ADDR_CH4_GAIN, 8'hA0);
        rd(adcgmd_pkg::ADDR_MISC_CTRL, 8'h02);
        rd(adcgmd_pkg::ADDR_FAULT_EN, 8'h0F);
        rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'h00);
        wr(8'h0F, 8'h55);
        rd(8'h0F, 8'h00);
        wr(adcgmd_pkg::ADDR_CH2_GAIN, 8'h00);
        chk("level2", o_gain_level[0], 10'h1E0);
        rd(adcgmd_pkg::ADDR_CH2_GAIN, 8'h00);
        wr(adcgmd_pkg::ADDR_CH3_GAIN, 8'hFE);
        chk("level3", o_gain_level[1], 10'h2E6);
        wr(adcgmd_pkg::ADDR_CH4_GAIN, 8'hFF);
        chk("silent", {7'h00, o_gain_silent}, 10'h004);
        chk("level4", o_gain_level[2], 10'h2E3);
        // Every combine mode, with silence and calibration toggled; reserved bits 3:1 kept at 001.
        for (int m = 0; m < 4; m++) begin
            d = {2'(m), 1'b0, m[0], 3'h1, m[1]};
            wr(adcgmd_pkg::ADDR_MISC_CTRL, d);
            chk("combine", {8'h00, o_channel_combine_select}, (m == 3) ? 10'h000 : 10'(m));
            chk("silence", {9'h000, o_global_silence}, {9'h000, m[0]});
            chk("cal", {9'h000, o_offset_calibration_start}, {9'h000, m[1]});
            chk("silent", {7'h00, o_gain_silent}, m[0] ? 10'h007 : 10'h004);
            rd(adcgmd_pkg::ADDR_MISC_CTRL, d);
        end
        // Each fault flag alone: it stays after the fault goes, and a read clears it.
        for (int i = 0; i < 7; i++) begin
            fault_set <= 7'(1 << i);
            repeat (6) @(posedge i_clk);
            fault_set <= 7'h00;
            repeat (6) @(posedge i_clk);
            rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'(1 << i));
            rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'h00);
        end
        wr(adcgmd_pkg::ADDR_FAULT_EN, 8'h0E);
        chk("check_on", {6'h00, o_fault_check_on}, 10'h00E);
        fault_set <= 7'h7F;
        repeat (6) @(posedge i_clk);
        fault_set <= 7'h00;
        repeat (6) @(posedge i_clk);
        rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'h00);
        wr(adcgmd_pkg::ADDR_CH1_FAULTS, 8'hFF);
        rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'h80);
        // Reset in mid-run: silence, calibration, silent flags, level 4 and four registers return to their values after reset.
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        chk("silence", {9'h000, o_global_silence}, 10'h000);
        chk("cal", {9'h000, o_offset_calibration_start}, 10'h000);
        chk("silent", {7'h00, o_gain_silent}, 10'h000);
        chk("level4", o_gain_level[2], 10'h000);
        rd(adcgmd_pkg::ADDR_CH2_GAIN, 8'hA0);
        rd(adcgmd_pkg::ADDR_MISC_CTRL, 8'h02);
        rd(adcgmd_pkg::ADDR_FAULT_EN, 8'h0F);
        rd(adcgmd_pkg::ADDR_CH1_FAULTS, 8'h00);
        summarize;
    end
endmodule

// ---- tb/adcgmd_regs_chk.sv ----
`timescale 1ns/10ps
module adcgmd_regs_chk (
    // Clock and reset.
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    // Register port.
    input wire logic [7:0]      i_reg_addr,
    input wire logic [7:0]      i_reg_wdata,
    input wire logic            i_reg_wr,
    input wire logic            i_reg_rd,
    input wire logic [7:0]      o_reg_rdata,
    input wire logic            o_reg_rvalid,
    // Fault levels and control outputs.
    input wire logic [6:0]      i_ch1_fault_raw,
    input wire logic [2:0][9:0] o_gain_level,
    input wire logic [2:0]      o_gain_silent,
    input wire logic [1:0]      o_channel_combine_select,
    input wire logic            o_global_silence,
    input wire logic            o_offset_calibration_start,
    input wire logic [3:0]      o_fault_check_on
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Write strobes per register, decoded once for all properties.
    wire misc_wr = i_reg_wr && (i_reg_addr == adcgmd_pkg::ADDR_MISC_CTRL);
    wire en_wr   = i_reg_wr && (i_reg_addr == adcgmd_pkg::ADDR_FAULT_EN);
    wire g2_wr   = i_reg_wr && (i_reg_addr == adcgmd_pkg::ADDR_CH2_GAIN);
    wire g4_wr   = i_reg_wr && (i_reg_addr == adcgmd_pkg::ADDR_CH4_GAIN);

    AST_RVALID_AFTER_READ: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe gave no valid pulse");
    AST_RVALID_ONLY_READ: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("valid pulse without read strobe");
    AST_SILENCE_WRITE: assert property (misc_wr |-> ##2 o_global_silence == $past(i_reg_wdata[4], 2))
        else $error("global silence does not follow bit 4");
    AST_CAL_WRITE: assert property (misc_wr |-> ##2 o_offset_calibration_start == $past(i_reg_wdata[0], 2))
        else $error("calibration start does not follow bit 0");
    AST_COMBINE_WRITE: assert property (misc_wr && i_reg_wdata[7:6] != 2'h3
        |-> ##2 o_channel_combine_select == $past(i_reg_wdata[7:6], 2))
        else $error("combine select does not follow bits 7:6");
    AST_MUTE_ALL: assert property (o_global_silence |-> o_gain_silent == 3'h7)
        else $error("global silence left a channel audible");
    AST_ENABLE_WRITE: assert property (en_wr |-> ##2 o_fault_check_on == $past(i_reg_wdata[3:0], 2))
        else $error("fault check enables do not follow write");
    AST_GAIN_LEVEL: assert property (g2_wr |-> ##2 o_gain_level[0] == 10'(480 - 3 * $past(i_reg_wdata, 2)))
        else $error("channel 2 level not decoded from code");
    AST_GAIN_MUTE: assert property (g4_wr && i_reg_wdata == 8'hFF |-> ##2 o_gain_silent[2])
        else $error("mute code left channel 4 audible");

    // Main scenarios reached by the bench.
    cover property (misc_wr && i_reg_wdata[4]);
    cover property (o_reg_rvalid && o_reg_rdata[6]);
    cover property (o_gain_silent[2] && !o_global_silence);
endmodule
bind adcgmd_regs adcgmd_regs_chk u_chk (.*);
